// ==== design/bsc_core.sv ====
// Switch sequencing, soft start, foldback, power good and protection of a buck controller.
// Assumes comparator bundle from analog pins and a soft-start pin code from an ADC on clk_i.
//
// Operation
// - High side on at each period start
// - Peak trip: high off, low on till period
// - Enable comparator starts and stops regulator
// - Sync clock: switching edge half period later
// - Internal soft start spans 1600 periods
// - Target is minimum of three references
// - Without sync lock, block reverse current until soft start passes feedback
// - Power good only while feedback in window
// - Power good deglitch 1024 up, 16 down
// - Soft-start foldback: full, half, quarter rate
// - Current limit ends high side, counts event
// - Hiccup at ten events, or low feedback after soft start
// - Hiccup waits 4096 cycles, then retries or, under current limit, waits again
// - Sink limit: both off until next period
// - Overvoltage: both off from 0.7 to 0.63
// - Undervoltage lockout shuts down, restarts softly
// - Over temperature stops, restarts with soft start
`timescale 1ns/1ps
module bsc_core
    import bsc_pkg::*;
#(
    parameter int unsigned OSC_PER = OSC_PER_DEF,
    parameter logic [SS_W-1:0] REF_CODE = SS_W'(SS_PERIODS)
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire bsc_cmp_s cmp_i,
    input wire logic [SS_W-1:0] ext_ss_code_i,
    output logic hs_on_o,
    output logic ls_on_o,
    output logic power_good_out_o,
    output logic power_good_out_oe_o,
    output logic [SS_W-1:0] target_o
);
    // Comparator synchroniser; stage one feeds only stage two
    bsc_cmp_s cmp_m, cmp_s;
    logic sync_d;

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            cmp_m <= '0;
            cmp_s <= '0;
            sync_d <= 1'b0;
        end else begin
            cmp_m <= cmp_i;
            cmp_s <= cmp_m;
            sync_d <= cmp_s.sync_clk;
        end
    end

    logic enable;
    assign enable = cmp_s.en_above && cmp_s.supply_ok && !cmp_s.over_temp;

    // Internal oscillator
    logic [SYNC_W-1:0] osc_cnt, next_osc_cnt;
    logic osc_tick;
    always_comb begin
        osc_tick = (osc_cnt == SYNC_W'(OSC_PER - 1));
        next_osc_cnt = osc_tick ? '0 : osc_cnt + 1'b1;
    end

    // Sync clock measurement and half-period placement
    logic [SYNC_W-1:0] sy_cnt, next_sy_cnt, sy_dly, next_sy_dly;
    logic sy_lock, next_sy_lock, sy_arm, next_sy_arm, sy_tick;
    logic sy_edge;
    always_comb begin
        sy_edge = cmp_s.sync_clk && !sync_d;
        next_sy_cnt = (sy_cnt == '1) ? sy_cnt : sy_cnt + 1'b1;
        next_sy_lock = sy_lock;
        next_sy_dly = sy_dly;
        next_sy_arm = sy_arm;
        sy_tick = 1'b0;
        if (sy_arm) begin
            if (sy_dly <= SYNC_W'(1)) begin
                sy_tick = sy_lock;
                next_sy_arm = 1'b0;
            end else begin
                next_sy_dly = sy_dly - 1'b1;
            end
        end
        if (sy_cnt > SYNC_W'(SYNC_PER_MAX)) begin
            next_sy_lock = 1'b0;
        end
        if (sy_edge) begin
            next_sy_cnt = SYNC_W'(1);
            next_sy_lock = (sy_cnt >= SYNC_W'(SYNC_PER_MIN))
                && (sy_cnt <= SYNC_W'(SYNC_PER_MAX));
            next_sy_dly = sy_cnt >> 1;
            next_sy_arm = 1'b1;
        end
    end

    // Base period tick and foldback gating
    logic base_tick, pstart;
    logic [FOLD_W-1:0] fold, next_fold;
    bsc_ctrl_e ctrl, next_ctrl;
    always_comb begin
        base_tick = sy_lock ? sy_tick : osc_tick;
        next_fold = base_tick ? fold + 1'b1 : fold;
        pstart = base_tick;
        if (ctrl == C_SS) begin
            if (!cmp_s.fb_ge_0p2) begin
                pstart = base_tick && (fold == FOLD_ZERO);
            end else if (!cmp_s.fb_ge_0p4) begin
                pstart = base_tick && !fold[0];
            end
        end
    end

    // Regulator control: soft start, hiccup, overvoltage, pre-bias
    logic [SS_W-1:0] ss_cnt, next_ss_cnt;
    logic [OC_W-1:0] oc_cnt, next_oc_cnt;
    logic [HIC_W-1:0] hic_cnt, next_hic_cnt;
    logic ovp_hold, next_ovp_hold, prebias, next_prebias;
    logic oc_event;
    always_comb begin
        next_ctrl = ctrl;
        next_ss_cnt = ss_cnt;
        next_oc_cnt = oc_cnt;
        next_hic_cnt = hic_cnt;
        next_ovp_hold = ovp_hold;
        next_prebias = prebias;
        if (cmp_s.fb_ge_0p7) begin
            next_ovp_hold = 1'b1;
        end else if (!cmp_s.fb_ge_0p63) begin
            next_ovp_hold = 1'b0;
        end
        if (cmp_s.ss_above_fb) begin
            next_prebias = 1'b0;
        end
        if (oc_event && oc_cnt != OC_W'(OC_LIMIT)) begin
            next_oc_cnt = oc_cnt + 1'b1;
        end
        unique case (ctrl)
            C_OFF: begin
                next_ss_cnt = '0;
                next_oc_cnt = '0;
                next_prebias = 1'b1;
                if (enable) begin
                    next_ctrl = C_SS;
                end
            end
            C_SS: begin
                if (base_tick && ss_cnt != SS_W'(SS_PERIODS)) begin
                    next_ss_cnt = ss_cnt + 1'b1;
                end
                if (ss_cnt == SS_W'(SS_PERIODS)) begin
                    next_ctrl = C_RUN;
                end
                if (oc_cnt == OC_W'(OC_LIMIT)) begin
                    next_ctrl = C_HICCUP;
                    next_hic_cnt = '0;
                end
            end
            C_RUN: begin
                if (oc_cnt == OC_W'(OC_LIMIT) || !cmp_s.fb_ge_0p4) begin
                    next_ctrl = C_HICCUP;
                    next_hic_cnt = '0;
                end
            end
            C_HICCUP: begin
                next_hic_cnt = hic_cnt + 1'b1;
                if (hic_cnt == HIC_W'(HICCUP_CYC - 1)) begin
                    next_hic_cnt = '0;
                    if (!cmp_s.cur_limit) begin
                        next_ctrl = C_SS;
                        next_ss_cnt = '0;
                        next_oc_cnt = '0;
                        next_prebias = 1'b1;
                    end
                end
            end
        endcase
        if (!enable) begin
            next_ctrl = C_OFF;
            next_hic_cnt = '0;
        end
    end

    // Switch sequencer with non-overlap gaps
    bsc_sw_e sw, next_sw;
    logic [DT_W-1:0] dt_cnt, next_dt_cnt;
    logic run, dt_done;
    always_comb begin
        run = (ctrl == C_SS || ctrl == C_RUN) && !ovp_hold;
        dt_done = (dt_cnt <= DT_W'(1));
        next_sw = sw;
        next_dt_cnt = dt_done ? dt_cnt : dt_cnt - 1'b1;
        oc_event = 1'b0;
        unique case (sw)
            S_IDLE, S_OFF: begin
                if (pstart) begin
                    next_sw = S_DT_HI;
                    next_dt_cnt = DT_W'(NONOVL_CYC);
                end
            end
            S_DT_HI: begin
                if (dt_done) begin
                    next_sw = S_HIGH;
                end
            end
            S_HIGH: begin
                if (cmp_s.peak_trip || cmp_s.cur_limit) begin
                    next_sw = S_DT_LO;
                    next_dt_cnt = DT_W'(NONOVL_CYC);
                    oc_event = cmp_s.cur_limit;
                end
            end
            S_DT_LO: begin
                if (dt_done) begin
                    next_sw = S_LOW;
                end
            end
            S_LOW: begin
                if (pstart) begin
                    next_sw = S_DT_HI;
                    next_dt_cnt = DT_W'(NONOVL_CYC);
                end else if (cmp_s.sink_limit) begin
                    next_sw = S_OFF;
                end
            end
        endcase
        if (!run) begin
            next_sw = S_IDLE;
        end
    end

    // Power-good deglitch, counted in switching periods
    logic pg, next_pg;
    logic [PG_W-1:0] pg_cnt, next_pg_cnt;
    always_comb begin
        next_pg = pg;
        next_pg_cnt = pg_cnt;
        if (ctrl == C_OFF) begin
            next_pg = 1'b0;
            next_pg_cnt = '0;
        end else if (pg == cmp_s.fb_in_window) begin
            next_pg_cnt = '0;
        end else if (base_tick) begin
            next_pg_cnt = pg_cnt + 1'b1;
            if (!pg && pg_cnt == PG_W'(PG_RISE_CYC - 1)) begin
                next_pg = 1'b1;
                next_pg_cnt = '0;
            end
            if (pg && pg_cnt == PG_W'(PG_FALL_CYC - 1)) begin
                next_pg = 1'b0;
                next_pg_cnt = '0;
            end
        end
    end

    // Reference selection; pin code is already in reference units
    logic [SS_W-1:0] next_target;
    always_comb begin
        next_target = REF_CODE;
        if (ss_cnt < next_target) begin
            next_target = ss_cnt;
        end
        if (ext_ss_code_i < next_target) begin
            next_target = ext_ss_code_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            osc_cnt <= '0;
            sy_cnt <= '0;
            sy_dly <= '0;
            sy_lock <= 1'b0;
            sy_arm <= 1'b0;
            fold <= '0;
            ctrl <= C_OFF;
            ss_cnt <= '0;
            oc_cnt <= '0;
            hic_cnt <= '0;
            ovp_hold <= 1'b0;
            prebias <= 1'b1;
            sw <= S_IDLE;
            dt_cnt <= '0;
            pg <= 1'b0;
            pg_cnt <= '0;
            hs_on_o <= 1'b0;
            ls_on_o <= 1'b0;
            power_good_out_o <= 1'b0;
            power_good_out_oe_o <= 1'b1;
            target_o <= '0;
        end else begin
            osc_cnt <= next_osc_cnt;
            sy_cnt <= next_sy_cnt;
            sy_dly <= next_sy_dly;
            sy_lock <= next_sy_lock;
            sy_arm <= next_sy_arm;
            fold <= next_fold;
            ctrl <= next_ctrl;
            ss_cnt <= next_ss_cnt;
            oc_cnt <= next_oc_cnt;
            hic_cnt <= next_hic_cnt;
            ovp_hold <= next_ovp_hold;
            prebias <= next_prebias;
            sw <= next_sw;
            dt_cnt <= next_dt_cnt;
            pg <= next_pg;
            pg_cnt <= next_pg_cnt;
            // Drives follow the next state so both come straight from flops
            hs_on_o <= (next_sw == S_HIGH);
            // Without reverse-current sensing or sync lock, low side stays off while pre-biased
            ls_on_o <= (next_sw == S_LOW) && !(next_prebias && !sy_lock);
            power_good_out_o <= 1'b0;
            power_good_out_oe_o <= !next_pg;
            target_o <= next_target;
        end
    end
endmodule

// ==== shared/bsc_pkg.sv ====
// Constants, states and the comparator bundle of the buck switch controller.
// Assumes a single 20 MHz clock; non-overlap and sync limits are derived from CLK_HZ.
package bsc_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
    // Non-overlap between switch transitions, least time rounds up
    localparam int unsigned NONOVL_NS = 100;
    localparam int unsigned NONOVL_CYC = (NONOVL_NS * CLK_MHZ + 999) / 1000;
    // Accepted sync clock range; shortest period rounds up, longest down
    localparam int unsigned SYNC_FMAX_HZ = 1_400_000;
    localparam int unsigned SYNC_FMIN_HZ = 200_000;
    localparam int unsigned SYNC_PER_MIN = (CLK_HZ + SYNC_FMAX_HZ - 1) / SYNC_FMAX_HZ;
    localparam int unsigned SYNC_PER_MAX = CLK_HZ / SYNC_FMIN_HZ;
    localparam int unsigned SYNC_W = 8;
    // Internal oscillator default near 600 kHz
    localparam int unsigned OSC_PER_DEF = 33;
    localparam int unsigned SS_PERIODS = 1600;
    localparam int unsigned SS_W = 11;
    localparam int unsigned OC_LIMIT = 10;
    localparam int unsigned OC_W = 4;
    localparam int unsigned HICCUP_CYC = 4096;
    localparam int unsigned HIC_W = 13;
    localparam int unsigned PG_RISE_CYC = 1024;
    localparam int unsigned PG_FALL_CYC = 16;
    localparam int unsigned PG_W = 11;
    localparam int unsigned DT_W = 4;
    localparam int unsigned FOLD_W = 2;
    localparam logic [FOLD_W-1:0] FOLD_ZERO = 2'h0;

    typedef enum logic [1:0] {
        C_OFF = 2'h0,
        C_SS = 2'h1,
        C_RUN = 2'h3,
        C_HICCUP = 2'h2
    } bsc_ctrl_e;

    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_DT_HI = 3'h1,
        S_HIGH = 3'h3,
        S_DT_LO = 3'h2,
        S_LOW = 3'h6,
        S_OFF = 3'h7
    } bsc_sw_e;

    // Digitised comparator results, all asynchronous to clk_i
    typedef struct packed {
        logic en_above;       // Enable above rising threshold, hysteresis in comparator
        logic supply_ok;      // Input supply above lockout release, hysteresis in comparator
        logic over_temp;      // Over temperature, hysteresis in comparator
        logic peak_trip;      // Peak inductor current reached PWM demand
        logic cur_limit;      // Peak current limit reached
        logic sink_limit;     // Sink current limit reached
        logic fb_ge_0p4;      // Feedback at least 0.4 V
        logic fb_ge_0p2;      // Feedback at least 0.2 V
        logic fb_ge_0p7;      // Feedback reached 0.7 V
        logic fb_ge_0p63;     // Feedback still at or above 0.63 V
        logic fb_in_window;   // Feedback inside power-good window
        logic ss_above_fb;    // Soft-start value above feedback
        logic sync_clk;       // External synchronisation clock
    } bsc_cmp_s;
endpackage

// ==== bench/bsc_core_asserts.sv ====
// Port checker for the buck switch core.
// Assumes a bind from the bench that hands on both parameters.
`timescale 1ns/1ps
module bsc_core_asserts
    import bsc_pkg::*;
#(
    parameter int unsigned OSC_PER = OSC_PER_DEF,
    parameter logic [SS_W-1:0] REF_CODE = SS_W'(SS_PERIODS)
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire bsc_cmp_s cmp_i,
    input wire logic [SS_W-1:0] ext_ss_code_i,
    input wire logic hs_on_o,
    input wire logic ls_on_o,
    input wire logic power_good_out_o,
    input wire logic power_good_out_oe_o,
    input wire logic [SS_W-1:0] target_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    a_no_overlap: assert property (!(hs_on_o && ls_on_o))
        else $error("both switches on");
    a_gap_low: assert property ($fell(hs_on_o) |-> !ls_on_o [*2])
        else $error("low side on too soon");
    a_gap_high: assert property ($rose(hs_on_o) |-> !$past(ls_on_o, 1) && !$past(ls_on_o, 2))
        else $error("high side on too soon");
    a_target_min: assert property (target_o <= REF_CODE && target_o <= $past(ext_ss_code_i))
        else $error("target above a reference");
    a_enable_off: assert property (!cmp_i.en_above [*5] |=> !hs_on_o && !ls_on_o && power_good_out_oe_o)
        else $error("switching while disabled");
    a_lockout_off: assert property (!cmp_i.supply_ok [*5] |=> !hs_on_o && !ls_on_o)
        else $error("switching in lockout");
    a_thermal_off: assert property (cmp_i.over_temp [*5] |=> !hs_on_o && !ls_on_o)
        else $error("switching while hot");
    a_ovp_off: assert property (cmp_i.fb_ge_0p7 [*5] |=> !hs_on_o && !ls_on_o)
        else $error("switching in overvoltage");
    a_sink_off: assert property (cmp_i.sink_limit [*5] |-> !(ls_on_o && $past(ls_on_o)))
        else $error("low side held in sink limit");
    a_pg_rise: assert property ($fell(power_good_out_oe_o) |->
        $past(cmp_i.fb_in_window, 4) && $past(cmp_i.fb_in_window, 8))
        else $error("power good without window");
    a_drain_low: assert property (power_good_out_o == 1'b0)
        else $error("power good data not low");
    c_high: cover property ($rose(hs_on_o));
    c_low: cover property ($rose(ls_on_o));
    c_good: cover property ($fell(power_good_out_oe_o));
    c_sink: cover property (cmp_i.sink_limit [*5]);
    c_sync: cover property ($rose(cmp_i.sync_clk));
endmodule

// ==== bench/bsc_partner.sv ====
// Power switch and current sense model: peak trip after a set on time.
// Assumes the high-side drive as input; trip drops once the switch opens.
`timescale 1ns/1ps
module bsc_partner
    import bsc_pkg::*;
(
    input wire logic clk_i,
    input wire logic hs_on_i,
    input wire logic [DT_W-1:0] on_cyc_i,
    output logic peak_trip_o
);
    logic [DT_W-1:0] on_cnt = '0;
    logic [DT_W-1:0] next_on_cnt;
    always_comb begin
        next_on_cnt = hs_on_i ? on_cnt + ((on_cnt == '1) ? 4'h0 : 4'h1) : 4'h0;
        peak_trip_o = hs_on_i && (on_cnt >= on_cyc_i);
    end
    always_ff @(posedge clk_i) begin
        on_cnt <= next_on_cnt;
    end
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench for the buck switch core beside a switch model.
// Assumes 20 MHz clock; short oscillator period keeps the run brief.
`timescale 1ns/1ps
module testbench;
    import bsc_pkg::*;
    localparam int unsigned OSC = 16;
    localparam logic [SS_W-1:0] REF = SS_W'(SS_PERIODS);
    localparam int LIMIT = 90000;
    // Sync period in clocks, inside the accepted window
    localparam int SYNC_T = 20;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    bsc_cmp_s cmp_tb = '0;
    bsc_cmp_s cmp;
    logic [SS_W-1:0] ext_ss = 11'h7FF;
    logic [DT_W-1:0] on_cyc = 4'h2;
    logic peak, hs, ls, pg, pg_oe;
    logic [SS_W-1:0] target;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    always #25 clk_i = ~clk_i;
    always_comb begin
        cmp = cmp_tb;
        cmp.peak_trip = peak;
    end
    bsc_partner u_sw (.clk_i(clk_i), .hs_on_i(hs), .on_cyc_i(on_cyc), .peak_trip_o(peak));
    bsc_core #(.OSC_PER(OSC), .REF_CODE(REF)) dut (.clk_i(clk_i), .srst_i(srst_i), .cmp_i(cmp),
        .ext_ss_code_i(ext_ss), .hs_on_o(hs), .ls_on_o(ls), .power_good_out_o(pg),
        .power_good_out_oe_o(pg_oe), .target_o(target));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches %0d total_checks %0d", mismatches, total_checks);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            test_done();
        end
    end
    // Cycles to next high-side rise, and low-side cycles on the way
    task automatic hs_rise(output int n, output int l);
        logic p;
        p = hs;
        n = 0;
        l = 0;
        while (n < 9000 && !(hs === 1'b1 && p === 1'b0)) begin
            p = hs;
            @(negedge clk_i);
            n++;
            l += int'(ls === 1'b1);
        end
    endtask
    task automatic count_on(input int cyc, output int n);
        n = 0;
        repeat (cyc) begin
            @(negedge clk_i);
            n += int'(hs === 1'b1 || ls === 1'b1);
        end
    endtask
    task automatic t_reset();
        @(negedge clk_i);
        chk({hs, ls, pg_oe}, 3'h1);
        chk(target, 11'h0);
    endtask
    task automatic t_start();
        int n, l, t0, pg_at, ss_at;
        pg_at = 0;
        ss_at = 0;
        @(posedge clk_i);
        t0 = cycles;
        cmp_tb <= '{en_above: 1, supply_ok: 1, fb_ge_0p4: 1, fb_ge_0p2: 1, fb_in_window: 1,
            default: 0};
        hs_rise(n, l);
        chk(n <= OSC + 8, 1);
        hs_rise(n, l);
        chk(l, 0);
        @(posedge clk_i);
        cmp_tb.ss_above_fb <= 1'b1;
        hs_rise(n, l);
        hs_rise(n, l);
        chk(n, OSC);
        chk(l > 0 && l < OSC, 1);
        while (cycles - t0 < 1700 * OSC) begin
            @(negedge clk_i);
            if (pg_at == 0 && pg_oe === 1'b0) pg_at = cycles - t0;
            if (ss_at == 0 && target === REF) ss_at = cycles - t0;
        end
        chk(pg_at >= 1023 * OSC && pg_at <= 1025 * OSC + 8, 1);
        chk(ss_at >= 1599 * OSC && ss_at <= 1601 * OSC + 8, 1);
    endtask
    task automatic t_ext();
        @(posedge clk_i);
        ext_ss <= 11'h123;
        repeat (3) @(negedge clk_i);
        chk(target, 11'h123);
        @(posedge clk_i);
        ext_ss <= 11'h7FF;
    endtask
    task automatic t_pgfall();
        int t0;
        @(posedge clk_i);
        t0 = cycles;
        cmp_tb.fb_in_window <= 1'b0;
        while (pg_oe !== 1'b1 && cycles - t0 < 40 * OSC) @(negedge clk_i);
        chk(cycles - t0 >= 15 * OSC && cycles - t0 <= 17 * OSC + 8, 1);
        @(posedge clk_i);
        cmp_tb.fb_in_window <= 1'b1;
    endtask
    task automatic t_sink();
        int n, l;
        @(posedge clk_i);
        cmp_tb.sink_limit <= 1'b1;
        hs_rise(n, l);
        hs_rise(n, l);
        chk(n, OSC);
        chk(l <= 1, 1);
        @(posedge clk_i);
        cmp_tb.sink_limit <= 1'b0;
    endtask
    task automatic t_ovp();
        int n, l;
        @(posedge clk_i);
        cmp_tb.fb_ge_0p7 <= 1'b1;
        cmp_tb.fb_ge_0p63 <= 1'b1;
        repeat (6) @(negedge clk_i);
        count_on(60, n);
        chk(n, 0);
        @(posedge clk_i);
        cmp_tb.fb_ge_0p7 <= 1'b0;
        count_on(60, n);
        chk(n, 0);
        @(posedge clk_i);
        cmp_tb.fb_ge_0p63 <= 1'b0;
        hs_rise(n, l);
        chk(n <= OSC + 8, 1);
    endtask
    task automatic t_fold();
        int n, l;
        @(posedge clk_i);
        cmp_tb.fb_ge_0p4 <= 1'b0;
        cmp_tb.fb_ge_0p2 <= 1'b0;
        repeat (6) @(negedge clk_i);
        count_on(HICCUP_CYC - 100, n);
        chk(n, 0);
        hs_rise(n, l);
        chk(n <= 200 + 4 * OSC, 1);
        hs_rise(n, l);
        chk(n, 4 * OSC);
        @(posedge clk_i);
        cmp_tb.fb_ge_0p2 <= 1'b1;
        hs_rise(n, l);
        hs_rise(n, l);
        chk(n, 2 * OSC);
        @(posedge clk_i);
        cmp_tb.fb_ge_0p4 <= 1'b1;
        hs_rise(n, l);
        hs_rise(n, l);
        chk(n, OSC);
    endtask
    task automatic t_oc();
        int n, l, k;
        k = 0;
        hs_rise(n, l);
        // Limit raised on a rising edge, after this period's high phase
        repeat (OSC / 2) @(posedge clk_i);
        cmp_tb.cur_limit <= 1'b1;
        n = 0;
        while (n < 8 * OSC) begin
            hs_rise(n, l);
            k += int'(n < 8 * OSC);
        end
        chk(k, OC_LIMIT);
        chk(n >= 9000, 1);
        @(posedge clk_i);
        cmp_tb.cur_limit <= 1'b0;
        hs_rise(n, l);
        chk(n <= HICCUP_CYC + 4 * OSC, 1);
        chk(target < 11'h10, 1);
    endtask
    // Sync clock: period follows it, switching edge near half period
    task automatic t_sync();
        int pr, at;
        logic p;
        pr = 0;
        at = 0;
        p = 1'b1;
        for (int c = 0; c < 8 * SYNC_T; c++) begin
            @(posedge clk_i);
            cmp_tb.sync_clk <= (c % SYNC_T < SYNC_T / 2);
            @(negedge clk_i);
            if (hs === 1'b1 && p === 1'b0) begin
                pr = at;
                at = c;
            end
            p = hs;
        end
        chk(at - pr, SYNC_T);
        // Slack covers input sync, edge detect and non-overlap
        chk(at % SYNC_T >= SYNC_T / 2 && at % SYNC_T <= SYNC_T / 2 + 8, 1);
        @(posedge clk_i);
        cmp_tb.sync_clk <= 1'b0;
        // Lock must lapse before the oscillator paces again
        repeat (SYNC_PER_MAX + 8) @(posedge clk_i);
    endtask
    task automatic t_off();
        int n, l;
        for (int i = 0; i < 3; i++) begin
            @(posedge clk_i);
            cmp_tb.en_above <= (i != 0);
            cmp_tb.supply_ok <= (i != 1);
            cmp_tb.over_temp <= (i == 2);
            repeat (6) @(negedge clk_i);
            chk({hs, ls, pg_oe}, 3'h1);
            chk(target, 11'h0);
            @(posedge clk_i);
            cmp_tb.en_above <= 1'b1;
            cmp_tb.supply_ok <= 1'b1;
            cmp_tb.over_temp <= 1'b0;
            hs_rise(n, l);
            chk(n <= 2 * OSC + 8 && target < 11'h10, 1);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        t_reset();
        t_start();
        t_ext();
        t_pgfall();
        t_sink();
        t_ovp();
        t_fold();
        t_oc();
        t_sync();
        t_off();
        test_done();
    end
endmodule
bind bsc_core bsc_core_asserts #(.OSC_PER(OSC_PER), .REF_CODE(REF_CODE)) u_chk (
    .clk_i(clk_i), .srst_i(srst_i), .cmp_i(cmp_i), .ext_ss_code_i(ext_ss_code_i),
    .hs_on_o(hs_on_o), .ls_on_o(ls_on_o), .power_good_out_o(power_good_out_o),
    .power_good_out_oe_o(power_good_out_oe_o), .target_o(target_o));
